/* File: dv/mpk_pins_model.sv */
// Partner model: push buttons and pull resistors on the six pins
`timescale 1ns/1ps
module mpk_pins_model
  import mpk_pkg::*;
(
  input  wire logic [MPK_NPINS-1:0] pin_out,
  input  wire logic [MPK_NPINS-1:0] pin_oe,
  input  wire logic [MPK_NPINS-1:0] pin_pullup,
  input  wire logic [MPK_NPINS-1:0] press,
  output logic      [MPK_NPINS-1:0] pin_in
);
  // Driven pin shows its output; otherwise a button or pull-up lifts it, idle buttons pull low
  always_comb
  begin
    for (int i = 0; i < MPK_NPINS; i++)
    begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (press[i] | pin_pullup[i]);
    end
  end
endmodule

/* File: dv/multi_pin_key_input_status_bench.sv */
// Self-checking bench of the multi-pin key block over APB
`timescale 1ns/1ps
module multi_pin_key_input_status_bench
  import mpk_pkg::*;
();
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic                 pready;
  logic                 pslverr;
  logic                 irq;
  logic                 err;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic [31:0]          rd;
  logic [MPK_NPINS-1:0] pin_in;
  logic [MPK_NPINS-1:0] pin_out;
  logic [MPK_NPINS-1:0] pin_oe;
  logic [MPK_NPINS-1:0] pin_pullup;
  logic [MPK_NPINS-1:0] press;
  int                   bad_count;
  int                   num_checks;
  int                   cycles;

  mpk_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .irq(irq));

  mpk_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .press(press), .pin_in(pin_in));

  // 50 ns clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // One APB transfer; the request stands until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // A wait for pready ends when pready is seen high at an edge, or at the hang guard
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  // Pins need the synchroniser and sample stage before any effect
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      finish_test;
    end
  end

  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, press} = '0;
    {bad_count, num_checks, cycles} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and an unmapped place
    rdchk("cfg", MPK_ADDR_CFG, 32'h0);
    rdchk("status", MPK_ADDR_STATUS, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    apb(1'b1, MPK_ADDR_IRQ_MK, 32'h2);
    // Single-pin key with all pins inputs
    press <= 6'h04;
    settle;
    rdchk("status", MPK_ADDR_STATUS, 32'h4);
    rdchk("press", MPK_ADDR_PRESS, 32'h4);
    rdchk("rise", MPK_ADDR_RISE, 32'h4);
    rdchk("rise", MPK_ADDR_RISE, 32'h0);
    press <= 6'h00;
    settle;
    rdchk("fall", MPK_ADDR_FALL, 32'h4);
    // Two pins high: false detection, freeze, blocked config
    press <= 6'h03;
    settle;
    apb(1'b0, MPK_ADDR_STATUS, 32'h0);
    chk("false", 32'h1, 32'(rd[MPK_ST_FALSE_BIT]));
    chk("irq", 32'h1, 32'(irq));
    press <= 6'h07;
    settle;
    apb(1'b0, MPK_ADDR_STATUS, 32'h0);
    chk("frozen", 32'h0, 32'(rd[2]));
    apb(1'b1, MPK_ADDR_CFG, 32'h1);
    apb(1'b0, MPK_ADDR_CFG, 32'h0);
    chk("cfg oe", 32'h0, 32'(rd[5:0]));
    chk("pin oe", 32'h0, 32'(pin_oe));
    apb(1'b0, MPK_ADDR_IRQ_ST, 32'h0);
    chk("cfg blk", 32'h1, 32'(rd[MPK_IRQ_CFGBLK]));
    // Lockup holds until every latched pin is low
    press <= 6'h01;
    settle;
    apb(1'b0, MPK_ADDR_STATUS, 32'h0);
    chk("false", 32'h1, 32'(rd[MPK_ST_FALSE_BIT]));
    press <= 6'h00;
    settle;
    rdchk("status", MPK_ADDR_STATUS, 32'h0);
    // The pair press itself left its pair key rise flag behind
    rdchk("rise", MPK_ADDR_RISE, 32'h40);
    apb(1'b1, MPK_ADDR_IRQ_ST, 32'h7);
    rdchk("irq st", MPK_ADDR_IRQ_ST, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    // One output: only first four inputs, flag words stay still
    apb(1'b1, MPK_ADDR_CFG, 32'h20);
    press <= 6'h10;
    settle;
    rdchk("status", MPK_ADDR_STATUS, 32'h800000);
    chk("pin oe", 32'h20, 32'(pin_oe));
    press <= 6'h01;
    settle;
    rdchk("status", MPK_ADDR_STATUS, 32'h800001);
    rdchk("rise", MPK_ADDR_RISE, 32'h0);
    // Three outputs leave exactly three inputs
    apb(1'b1, MPK_ADDR_CFG, 32'h38);
    press <= 6'h0f;
    settle;
    rdchk("status", MPK_ADDR_STATUS, 32'h800007);
    press <= 6'h00;
    // Two outputs set high together
    apb(1'b1, MPK_ADDR_CFG, 32'h30);
    apb(1'b1, MPK_ADDR_OUT, 32'h30);
    settle;
    apb(1'b0, MPK_ADDR_STATUS, 32'h0);
    chk("false", 32'h1, 32'(rd[MPK_ST_FALSE_BIT]));
    apb(1'b1, MPK_ADDR_OUT, 32'h10);
    settle;
    chk("pin out", 32'h10, 32'(pin_out));
    apb(1'b0, MPK_ADDR_STATUS, 32'h0);
    chk("false", 32'h1, 32'(rd[MPK_ST_FALSE_BIT]));
    apb(1'b1, MPK_ADDR_OUT, 32'h0);
    settle;
    apb(1'b0, MPK_ADDR_STATUS, 32'h0);
    chk("false", 32'h0, 32'(rd[MPK_ST_FALSE_BIT]));
    // Pin 5 pulled up permanently keeps a pair press harmless
    apb(1'b1, MPK_ADDR_CFG, 32'h800);
    press <= 6'h03;
    settle;
    rdchk("status", MPK_ADDR_STATUS, 32'h23);
    chk("pin pullup", 32'h20, 32'(pin_pullup));
    finish_test;
  end
endmodule

/* File: verilog/mpk_decode.sv */
// Key decoder: six single-pin keys plus fifteen two-pin combination keys
`timescale 1ns/1ps
module mpk_decode
  import mpk_pkg::*;
(
  input  wire logic [MPK_NPINS-1:0] pins,
  output logic      [MPK_NKEYS-1:0] keys
);
  // Single keys index 0..5, pair keys after them in (i,j) order
  genvar gi, gj;
  generate
    for (gi = 0; gi < MPK_NPINS; gi++)
    begin : g_single
      assign keys[gi] = pins[gi] && ($countones(pins) == 1); // [R03]
    end
    for (gi = 0; gi < MPK_NPINS; gi++)
    begin : g_row
      for (gj = gi + 1; gj < MPK_NPINS; gj++)
      begin : g_col
        localparam int K = MPK_NPINS + gi * (2 * MPK_NPINS - gi - 1) / 2 + (gj - gi - 1);
        // Pair key: exactly these two lines high, other four low
        assign keys[K] = pins[gi] && pins[gj] && ($countones(pins) == 2); // [R03]
      end
    end
  endgenerate
endmodule

/* File: verilog/mpk_pkg.sv */
// Package: register map, field layout and constants of the multi-pin key input block
package mpk_pkg;
  localparam int          MPK_NPINS      = 6;
  localparam int          MPK_NKEYS      = 21;
  localparam int          MPK_WORD_W     = 24;
  // Printed offsets are word indices (not all multiples of four)
  localparam logic [7:0]  MPK_IDX_STATUS = 8'h16;
  localparam logic [7:0]  MPK_IDX_RISE   = 8'h1a;
  localparam logic [7:0]  MPK_IDX_PRESS  = 8'h1b;
  localparam logic [7:0]  MPK_IDX_FALL   = 8'h1c;
  localparam logic [7:0]  MPK_IDX_CFG    = 8'h30;
  localparam logic [7:0]  MPK_IDX_OUT    = 8'h31;
  localparam logic [7:0]  MPK_IDX_IRQ_ST = 8'h32;
  localparam logic [7:0]  MPK_IDX_IRQ_MK = 8'h33;
  localparam logic [11:0] MPK_ADDR_STATUS = {2'b00, MPK_IDX_STATUS, 2'b00};
  localparam logic [11:0] MPK_ADDR_RISE   = {2'b00, MPK_IDX_RISE, 2'b00};
  localparam logic [11:0] MPK_ADDR_PRESS  = {2'b00, MPK_IDX_PRESS, 2'b00};
  localparam logic [11:0] MPK_ADDR_FALL   = {2'b00, MPK_IDX_FALL, 2'b00};
  localparam logic [11:0] MPK_ADDR_CFG    = {2'b00, MPK_IDX_CFG, 2'b00};
  localparam logic [11:0] MPK_ADDR_OUT    = {2'b00, MPK_IDX_OUT, 2'b00};
  localparam logic [11:0] MPK_ADDR_IRQ_ST = {2'b00, MPK_IDX_IRQ_ST, 2'b00};
  localparam logic [11:0] MPK_ADDR_IRQ_MK = {2'b00, MPK_IDX_IRQ_MK, 2'b00};
  // Status word fields
  localparam int          MPK_ST_FALSE_BIT = 22;
  localparam int          MPK_ST_MIXED_BIT = 23;
  // Config word fields: [5:0] output enables, [11:6] pull-ups
  localparam int          MPK_CFG_OE_LSB = 0;
  localparam int          MPK_CFG_PU_LSB = 6;
  localparam logic [5:0]  MPK_CFG_OE_RST = 6'h00;
  localparam logic [5:0]  MPK_CFG_PU_RST = 6'h00;
  localparam int          MPK_MIXED_MAX_IN = 4;
  // Interrupt bits
  localparam int          MPK_IRQ_W      = 3;
  localparam int          MPK_IRQ_KEY    = 0;
  localparam int          MPK_IRQ_FALSE  = 1;
  localparam int          MPK_IRQ_CFGBLK = 2;
endpackage

/* File: verilog/mpk_sync.sv */
// Two-flop synchroniser for the six pin inputs
`timescale 1ns/1ps
module mpk_sync
  import mpk_pkg::*;
#(
  parameter int W = MPK_NPINS
)(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_r <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

/* File: verilog/mpk_top.sv */
// Multi-function pin key input block with APB registers and the two-high lockup
// What this block does
// [R01] With any output configured, at most four key inputs are supported.
// [R02] Twenty-one key decoding works only when all six pins are inputs.
// [R03] Keys come from each of six pins alone and from pin pairs.
// [R04] With outputs, flag words rise/press/fall stop updating; use status word.
// [R05] Mixed use is limited to three inputs with three outputs.
// [R06] Exactly two pins high and four low flags a multi-pin key.
// [R07] The false detection happens whatever drives the two pins high.
// [R08] After false detection outputs work but status and flag words freeze.
// [R09] False detection during configuration blocks further configuration writes.
// [R10] Lockup clears only when every pin high at detection is low again.
// [R11] Users should hold one pin permanently high to suppress false detection.
// [R12] All six pins are sampled together; detection uses that registered sample.
`timescale 1ns/1ps
module mpk_top
  import mpk_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [MPK_NPINS-1:0] pin_in,
  output logic      [MPK_NPINS-1:0] pin_out,
  output logic      [MPK_NPINS-1:0] pin_oe,
  output logic      [MPK_NPINS-1:0] pin_pullup,
  output logic                      irq
);
  logic [MPK_NPINS-1:0]  pin_s;
  logic [MPK_NPINS-1:0]  sample_r;
  logic [MPK_NPINS-1:0]  oe_r;
  logic [MPK_NPINS-1:0]  pu_r;
  logic [MPK_NPINS-1:0]  out_r;
  logic [MPK_NPINS-1:0]  latch_r;
  logic                  false_r;
  logic                  cfgblk_r;
  logic [MPK_NKEYS-1:0]  keys;
  logic [MPK_NKEYS-1:0]  keys_prev_r;
  logic [MPK_WORD_W-1:0] status_r;
  logic [MPK_WORD_W-1:0] rise_r;
  logic [MPK_WORD_W-1:0] press_r;
  logic [MPK_WORD_W-1:0] fall_r;
  logic [MPK_IRQ_W-1:0]  irq_st_r;
  logic [MPK_IRQ_W-1:0]  irq_mk_r;
  logic [MPK_IRQ_W-1:0]  irq_ev;
  logic                  any_out;
  logic                  two_high;
  logic                  cfg_ok;
  logic                  wr_en;
  logic                  rd_en;
  logic                  addr_hit;
  logic [MPK_NKEYS-1:0]  key_mask;
  logic [MPK_NPINS-1:0]  in_cnt_mask;
  logic                  cfg_wr;
  logic [MPK_NKEYS-1:0]  key_rise;
  logic [MPK_NKEYS-1:0]  key_fall;

  // Pins come from outside the clock domain
  mpk_sync #(
    .W (MPK_NPINS)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pin_in),
    .dout    (pin_s)
  );

  // All six pins registered together in one sample
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample_r <= '0;
    else
      sample_r <= pin_s; // [R12]
  end

  // Cause of the two-high pattern does not matter, only the levels
  assign two_high = ($countones(sample_r) == 2); // [R06] [R07] [R12]
  assign any_out  = |oe_r;

  mpk_decode u_dec (
    .pins (sample_r),
    .keys (keys)
  );

  // False multi-pin state: set on two-high, cleared when latched pins all low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      false_r <= 1'b0;
      latch_r <= '0;
    end
    else if (!false_r && two_high)
    begin
      false_r <= 1'b1; // [R06]
      latch_r <= sample_r;
    end
    else if (false_r && ((latch_r & sample_r) == '0))
    begin
      // A fresh pair in the clearing cycle re-arms at once: set wins
      false_r <= two_high; // [R10]
      latch_r <= two_high ? sample_r : '0;
    end
  end

  // Configuration lock: false detection while configuring blocks more writes
  assign cfg_wr = wr_en && (paddr == MPK_ADDR_CFG);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfgblk_r <= 1'b0;
    else if (false_r && cfg_wr)
      cfgblk_r <= 1'b1; // [R09]
    else if (!false_r)
      cfgblk_r <= 1'b0;
  end
  assign cfg_ok = !false_r; // [R09]

  // Inputs beyond the fourth are ignored once any output exists
  always_comb
  begin
    int n;
    n           = 0;
    in_cnt_mask = '0;
    for (int i = 0; i < MPK_NPINS; i++)
    begin
      // With no output every pin counts; three outputs leave three inputs
      if (!oe_r[i] && (!any_out || n < MPK_MIXED_MAX_IN))
      begin
        in_cnt_mask[i] = 1'b1; // [R01] [R05]
        n = n + 1;
      end
    end
  end
  // Extended pair keys valid only with all pins as inputs
  assign key_mask = any_out ? {{(MPK_NKEYS-MPK_NPINS){1'b0}}, in_cnt_mask}
                            : {MPK_NKEYS{1'b1}}; // [R02]
  assign key_rise = keys & ~keys_prev_r & key_mask;
  assign key_fall = ~keys & keys_prev_r & key_mask;

  // Status word: counted input levels always track unless frozen
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_r <= '0;
    else if (!false_r)
    begin
      status_r                   <= '0;
      status_r[MPK_NPINS-1:0]    <= sample_r & ~oe_r & in_cnt_mask; // [R04] [R01]
      status_r[MPK_ST_MIXED_BIT] <= any_out;
    end
    else
      status_r[MPK_ST_FALSE_BIT] <= 1'b1; // [R08]
  end

  // Flag words update only with no outputs and no false state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      keys_prev_r <= '0;
      rise_r      <= '0;
      press_r     <= '0;
      fall_r      <= '0;
    end
    else if (!false_r && !any_out) // [R04] [R08]
    begin
      keys_prev_r <= keys;
      rise_r      <= (rise_r | {3'b000, key_rise});
      fall_r      <= (fall_r | {3'b000, key_fall});
      press_r     <= {3'b000, keys};
      if (rd_en && paddr == MPK_ADDR_RISE)
        rise_r <= {3'b000, key_rise}; // Read clears, new edge wins
      if (rd_en && paddr == MPK_ADDR_FALL)
        fall_r <= {3'b000, key_fall};
    end
  end

  // Software output and config registers; outputs run on in false state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      oe_r  <= MPK_CFG_OE_RST;
      pu_r  <= MPK_CFG_PU_RST;
      out_r <= '0;
    end
    else
    begin
      if (cfg_wr && cfg_ok)
      begin
        oe_r <= pwdata[MPK_CFG_OE_LSB +: MPK_NPINS];
        pu_r <= pwdata[MPK_CFG_PU_LSB +: MPK_NPINS];
      end
      if (wr_en && paddr == MPK_ADDR_OUT)
        out_r <= pwdata[MPK_NPINS-1:0]; // [R08]
    end
  end

  assign pin_out    = out_r;
  assign pin_oe     = oe_r;
  assign pin_pullup = pu_r;

  // Interrupt sources; set wins over write-one-to-clear
  assign irq_ev[MPK_IRQ_KEY]    = |key_rise && !false_r && !any_out;
  assign irq_ev[MPK_IRQ_FALSE]  = two_high && !false_r;
  assign irq_ev[MPK_IRQ_CFGBLK] = false_r && cfg_wr;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_st_r <= '0;
      irq_mk_r <= '0;
    end
    else
    begin
      if (wr_en && paddr == MPK_ADDR_IRQ_ST)
        irq_st_r <= (irq_st_r & ~pwdata[MPK_IRQ_W-1:0]) | irq_ev;
      else
        irq_st_r <= irq_st_r | irq_ev;
      if (wr_en && paddr == MPK_ADDR_IRQ_MK)
        irq_mk_r <= pwdata[MPK_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_st_r & irq_mk_r);

  // APB slave: zero wait states, unmapped addresses error
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && penable && !pwrite;
  assign pready   = 1'b1;
  assign addr_hit = (paddr == MPK_ADDR_STATUS) || (paddr == MPK_ADDR_RISE) ||
                    (paddr == MPK_ADDR_PRESS) || (paddr == MPK_ADDR_FALL) ||
                    (paddr == MPK_ADDR_CFG) || (paddr == MPK_ADDR_OUT) ||
                    (paddr == MPK_ADDR_IRQ_ST) || (paddr == MPK_ADDR_IRQ_MK);
  assign pslverr  = psel && penable && !addr_hit;

  // Read mux
  always_comb
  begin
    prdata = '0;
    unique case (paddr)
      MPK_ADDR_STATUS: prdata = {8'h00, status_r};
      MPK_ADDR_RISE:   prdata = {8'h00, rise_r};
      MPK_ADDR_PRESS:  prdata = {8'h00, press_r};
      MPK_ADDR_FALL:   prdata = {8'h00, fall_r};
      MPK_ADDR_CFG:    prdata = {19'h0, cfgblk_r, pu_r, oe_r};
      MPK_ADDR_OUT:    prdata = {26'h0, out_r};
      MPK_ADDR_IRQ_ST: prdata = {29'h0, irq_st_r};
      MPK_ADDR_IRQ_MK: prdata = {29'h0, irq_mk_r};
      default:         prdata = '0;
    endcase
  end

  // Checks
  property p_two_high_sets;
    @(posedge pclk) disable iff (!presetn)
    two_high |=> false_r;
  endproperty
  a_two_high_sets: assert property (p_two_high_sets) else $error("two-high did not set false state"); // [R06]

  property p_clear_needs_low;
    @(posedge pclk) disable iff (!presetn)
    (false_r && ((latch_r & sample_r) != '0)) |=> false_r;
  endproperty
  a_clear_needs_low: assert property (p_clear_needs_low) else $error("false state cleared too early"); // [R10]

  property p_status_frozen;
    @(posedge pclk) disable iff (!presetn)
    (false_r && $past(false_r)) |-> $stable(status_r[MPK_NPINS-1:0]);
  endproperty
  a_status_frozen: assert property (p_status_frozen) else $error("status moved while frozen"); // [R08]

  property p_flags_frozen;
    @(posedge pclk) disable iff (!presetn)
    (false_r || any_out) |=> $stable(press_r);
  endproperty
  a_flags_frozen: assert property (p_flags_frozen) else $error("flag word moved"); // [R04]

  property p_cfg_blocked;
    @(posedge pclk) disable iff (!presetn)
    (cfg_wr && false_r) |=> $stable(oe_r) && $stable(pu_r);
  endproperty
  a_cfg_blocked: assert property (p_cfg_blocked) else $error("config written while blocked"); // [R09]

  property p_max_inputs;
    @(posedge pclk) disable iff (!presetn)
    any_out |-> ($countones(key_mask) <= MPK_MIXED_MAX_IN);
  endproperty
  a_max_inputs: assert property (p_max_inputs) else $error("too many inputs with outputs"); // [R01]

  property p_no_pairs_mixed;
    @(posedge pclk) disable iff (!presetn)
    any_out |-> (key_mask[MPK_NKEYS-1:MPK_NPINS] == '0);
  endproperty
  a_no_pairs_mixed: assert property (p_no_pairs_mixed) else $error("pair keys with outputs"); // [R02]

  property p_sample_lag;
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> sample_r == $past(pin_s);
  endproperty
  a_sample_lag: assert property (p_sample_lag) else $error("sample not one cycle behind"); // [R12]

  property p_mixed_split;
    @(posedge pclk) disable iff (!presetn)
    ($countones(oe_r) == 3) |-> ($countones(key_mask) == 3);
  endproperty
  a_mixed_split: assert property (p_mixed_split) else $error("three outputs must leave three inputs"); // [R05]

  property p_clear_on_low;
    @(posedge pclk) disable iff (!presetn)
    (false_r && ((latch_r & sample_r) == '0) && !two_high) |=> !false_r;
  endproperty
  a_clear_on_low: assert property (p_clear_on_low) else $error("false state stuck after pins low"); // [R10]

  property p_single_key;
    @(posedge pclk) disable iff (!presetn)
    ($countones(sample_r) == 1) |-> (keys == {{(MPK_NKEYS-MPK_NPINS){1'b0}}, sample_r});
  endproperty
  a_single_key: assert property (p_single_key) else $error("single pin key wrong"); // [R03]

  property p_pair_key;
    @(posedge pclk) disable iff (!presetn)
    two_high |-> (($countones(keys[MPK_NKEYS-1:MPK_NPINS]) == 1) && (keys[MPK_NPINS-1:0] == '0));
  endproperty
  a_pair_key: assert property (p_pair_key) else $error("pair key wrong"); // [R03]

  property p_outputs_run;
    @(posedge pclk) disable iff (!presetn)
    (wr_en && (paddr == MPK_ADDR_OUT)) |=> (out_r == $past(pwdata[MPK_NPINS-1:0]));
  endproperty
  a_outputs_run: assert property (p_outputs_run) else $error("output write lost"); // [R08]

  // Detection steps: a fresh two-high sample, then the false state with its event bit
  sequence s_pair_seen;
    two_high && !false_r;
  endsequence

  sequence s_pair_flagged;
    false_r && irq_st_r[MPK_IRQ_FALSE];
  endsequence

  property p_pair_flagged;
    @(posedge pclk) disable iff (!presetn)
    s_pair_seen |=> s_pair_flagged;
  endproperty
  a_pair_flagged: assert property (p_pair_flagged) else $error("pair not flagged"); // [R06]
endmodule
